// ==== rtl/ctc_pkg.sv ====
// Package of constants and types for the control timer counter core
package ctc_pkg;
    // ------------------------------------------------------------
    // Event action codes
    // ------------------------------------------------------------
    localparam logic [2:0] CTC_ACT_OFF = 3'h0;
    localparam logic [2:0] CTC_ACT_RESTART = 3'h1;
    localparam logic [2:0] CTC_ACT_DIR = 3'h2;
    localparam logic [2:0] CTC_ACT_STOP = 3'h3;
    localparam logic [2:0] CTC_ACT_START = 3'h3;
    localparam logic [2:0] CTC_ACT_STEP = 3'h4;
    localparam logic [2:0] CTC_ACT_COUNT = 3'h5;
    localparam logic [2:0] CTC_ACT_FAULT = 3'h7;
    // ------------------------------------------------------------
    // Command codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] CTC_CMD_NONE = 2'h0;
    localparam logic [1:0] CTC_CMD_RESTART = 2'h1;
    localparam logic [1:0] CTC_CMD_STOP = 2'h2;
    localparam logic [2:0] CTC_DIV_RST = 3'h0;
    localparam logic [1:0] CTC_SYNC_RST = 2'h0;
    localparam logic [1:0] CTC_SYNC_SRC = 2'h0;
    localparam logic [1:0] CTC_SYNC_DIV = 2'h1;
    localparam int CTC_MAX_DIV_SHIFT = 10;
    localparam logic [9:0] CTC_PRE_RST = 10'h000;
    // Divider terminal counts for divide codes 7 down to 0
    localparam logic [7:0][9:0] CTC_PRE_LIM = {10'h3ff, 10'h0ff, 10'h03f,
        10'h00f, 10'h007, 10'h003, 10'h001, 10'h000};
    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CTC_STOPPED = 2'b01,
        CTC_RUNNING = 2'b10
    } ctc_state_t;
endpackage

// ==== rtl/ctc_core.sv ====
// Counter core of the control timer unit
// Summary of operation
// - Protected fields ignore writes while enabled
// - Control A protected fields accepted only with enable-set write; event control fields with any write while disabled
// - Enable bit on/off; soft reset clears all
// - Prescaler divides 1 to 1024, bypassed counting
// - Update on source or prescaled clock
// - Count per tick, direction bit selects
// - Top wraps to zero, zero reloads top
// - Single run halts at wrap
// - Counter write beats count; direction changeable
// - Restart value zero up, top down; start from stop keeps count
// - Command stop halts counter
// - Action b stop code pauses counter
// - Restart while running reloads or clears, sets flag
// - Restart action: first event starts counter
// - Start action: event starts stopped counter
// - Count action steps by direction
// - Direction action: event level sets direction
// - Step action: line a up, b down
// - Fault action stops, forces channel outputs
// - Actions off: enabling starts counter
// - Top from period or channel zero
`timescale 1ns/1ns
module ctc_core
    import ctc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int CHANNELS = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Control A write port
    input wire logic ctla_we_in,
    input wire logic enable_wdata_in,
    input wire logic soft_reset_bit_in,
    input wire logic [2:0] divide_sel_in,
    input wire logic [1:0] divide_sync_field_in,
    // Event control and driver control write port
    input wire logic cfg_we_in,
    input wire logic [2:0] event_action_a_in,
    input wire logic [2:0] event_action_b_in,
    input wire logic restart_event_out_bit_in,
    input wire logic top_from_cc0_in,
    input wire logic [CHANNELS-1:0] fault_force_enable_bits_in,
    input wire logic [CHANNELS-1:0] fault_force_value_bits_in,
    // Control B set / clear strobes
    input wire logic [1:0] cmd_in,
    input wire logic dir_set_in,
    input wire logic dir_clr_in,
    input wire logic single_run_set_in,
    input wire logic single_run_clr_in,
    // Counter and top values
    input wire logic count_we_in,
    input wire logic [WIDTH-1:0] count_wdata_in,
    input wire logic [WIDTH-1:0] period_in,
    input wire logic [WIDTH-1:0] cc0_in,
    input wire logic [CHANNELS-1:0] channel_wave_in,
    // Events, one-cycle pulses (line b level for direction)
    input wire logic event_line_a_in,
    input wire logic event_line_b_in,
    // Flag clear, write one to clear
    input wire logic wrap_flag_clr_in,
    input wire logic restart_flag_clr_in,
    output logic enable_out,
    output logic running_out,
    output logic dir_out,
    output logic [WIDTH-1:0] count_out,
    output logic wrap_flag_out,
    output logic restart_flag_out,
    output logic restart_event_out,
    output logic [CHANNELS-1:0] channel_out
);
    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    logic enable_reg;
    logic [2:0] divide_reg;
    logic [1:0] sync_reg;
    logic [2:0] act_a_reg;
    logic [2:0] act_b_reg;
    logic trg_eo_reg;
    logic top_cc0_reg;
    logic [CHANNELS-1:0] nre_reg;
    logic [CHANNELS-1:0] nrv_reg;
    logic dir_reg;
    logic single_reg;
    logic fault_reg;
    logic [WIDTH-1:0] count_reg;
    logic wrap_reg;
    logic trg_reg;
    logic trg_ev_reg;
    logic [9:0] pre_reg;
    ctc_state_t state_reg;
    logic srst;
    logic prot_ok;
    assign srst = !rst_n_in || (ctla_we_in && soft_reset_bit_in);
    // Protected writes allowed only while disabled and with the enable bit set
    assign prot_ok = !enable_reg && (!ctla_we_in || enable_wdata_in);

    // Control A
    always_ff @(posedge clk_in) begin
        if (srst) begin
            enable_reg <= 1'b0;
            divide_reg <= CTC_DIV_RST;
            sync_reg <= CTC_SYNC_RST;
        end else if (ctla_we_in) begin
            enable_reg <= enable_wdata_in;
            if (prot_ok) begin
                divide_reg <= divide_sel_in;
                sync_reg <= divide_sync_field_in;
            end
        end
    end

    // Event and driver control, enable-protected
    always_ff @(posedge clk_in) begin
        if (srst) begin
            act_a_reg <= CTC_ACT_OFF;
            act_b_reg <= CTC_ACT_OFF;
            trg_eo_reg <= 1'b0;
            top_cc0_reg <= 1'b0;
            nre_reg <= '0;
            nrv_reg <= '0;
        end else if (cfg_we_in && !enable_reg) begin
            act_a_reg <= event_action_a_in;
            act_b_reg <= event_action_b_in;
            trg_eo_reg <= restart_event_out_bit_in;
            top_cc0_reg <= top_from_cc0_in;
            nre_reg <= fault_force_enable_bits_in;
            nrv_reg <= fault_force_value_bits_in;
        end
    end
    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    logic [WIDTH-1:0] top;
    logic ev_restart, ev_start, ev_stop, ev_fault, ev_count;
    logic ev_inc, ev_dec, events_off, cmd_restart, cmd_stop;
    logic bypass;
    assign top = top_cc0_reg ? cc0_in : period_in;
    assign ev_restart = (event_line_a_in && act_a_reg == CTC_ACT_RESTART)
        || (event_line_b_in && act_b_reg == CTC_ACT_RESTART);
    assign ev_start = event_line_a_in && act_a_reg == CTC_ACT_START;
    assign ev_stop = event_line_b_in && act_b_reg == CTC_ACT_STOP;
    assign ev_fault = (event_line_a_in && act_a_reg == CTC_ACT_FAULT)
        || (event_line_b_in && act_b_reg == CTC_ACT_FAULT);
    assign ev_count = event_line_a_in && act_a_reg == CTC_ACT_COUNT;
    assign ev_inc = event_line_a_in && act_a_reg == CTC_ACT_STEP;
    assign ev_dec = event_line_b_in && act_b_reg == CTC_ACT_STEP;
    assign bypass = act_a_reg == CTC_ACT_COUNT
        || act_a_reg == CTC_ACT_STEP || act_b_reg == CTC_ACT_STEP;
    assign events_off = act_a_reg != CTC_ACT_RESTART
        && act_a_reg != CTC_ACT_START && act_b_reg != CTC_ACT_RESTART;
    assign cmd_restart = cmd_in == CTC_CMD_RESTART;
    assign cmd_stop = cmd_in == CTC_CMD_STOP;
    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    logic [9:0] pre_lim;
    logic pre_tick;
    logic tick;
    assign pre_lim = CTC_PRE_LIM[divide_reg];
    assign pre_tick = (pre_reg == pre_lim);

    // Divider counter; restart resets it in source-sync mode
    always_ff @(posedge clk_in) begin
        if (srst || !enable_reg || state_reg != CTC_RUNNING) begin
            pre_reg <= CTC_PRE_RST;
        end else if (pre_tick || ((cmd_restart || ev_restart)
                     && sync_reg == CTC_SYNC_SRC)) begin
            pre_reg <= CTC_PRE_RST;
        end else begin
            pre_reg <= pre_reg + 10'h001;
        end
    end

    // Count tick takes event ticks in bypass, else prescaler ticks
    assign tick = state_reg == CTC_RUNNING
        && (bypass ? (ev_count || ev_inc || ev_dec) : pre_tick);
    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------
    logic do_restart, wrap_now, cur_dir, up_step;
    assign do_restart = enable_reg && (cmd_restart || ev_restart
        || (ev_start && state_reg == CTC_STOPPED));
    assign cur_dir = (act_b_reg == CTC_ACT_DIR) ? event_line_b_in : dir_reg;
    assign up_step = ev_inc ? 1'b1 : ev_dec ? 1'b0 : !cur_dir;
    assign wrap_now = tick && (up_step ? count_reg == top
        : count_reg == '0);

    always_ff @(posedge clk_in) begin
        if (srst || !enable_reg) begin
            state_reg <= CTC_STOPPED;
        end else begin
            case (state_reg)
                CTC_STOPPED: begin
                    if (fault_reg || ev_fault || cmd_stop || ev_stop) begin
                        state_reg <= CTC_STOPPED;
                    end else if (do_restart) begin
                        state_reg <= CTC_RUNNING;
                    end
                end
                CTC_RUNNING: begin
                    if (cmd_stop || ev_stop || ev_fault) begin
                        state_reg <= CTC_STOPPED;
                    end else if (wrap_now && single_reg
                                 && !do_restart) begin
                        state_reg <= CTC_STOPPED;
                    end
                end
                default: state_reg <= CTC_STOPPED;
            endcase
        end
        // Enabling with actions off starts at once
        if (!srst && ctla_we_in && enable_wdata_in && !enable_reg
            && events_off) begin
            state_reg <= CTC_RUNNING;
        end
    end

    // Fault latch holds channel override until disable
    always_ff @(posedge clk_in) begin
        if (srst || !enable_reg) begin
            fault_reg <= 1'b0;
        end else if (ev_fault) begin
            fault_reg <= 1'b1;
        end
    end

    // Control B bits: direction and single run
    always_ff @(posedge clk_in) begin
        if (srst) begin
            dir_reg <= 1'b0;
            single_reg <= 1'b0;
        end else begin
            if (act_b_reg == CTC_ACT_DIR && enable_reg) begin
                dir_reg <= event_line_b_in;
            end else if (dir_set_in) begin
                dir_reg <= 1'b1;
            end else if (dir_clr_in) begin
                dir_reg <= 1'b0;
            end
            if (single_run_set_in) begin
                single_reg <= 1'b1;
            end else if (single_run_clr_in) begin
                single_reg <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst) begin
            count_reg <= '0;
        end else if (count_we_in) begin
            count_reg <= count_wdata_in;
        end else if (do_restart && state_reg == CTC_RUNNING) begin
            count_reg <= cur_dir ? top : '0;
        end else if (tick) begin
            if (wrap_now) begin
                count_reg <= up_step ? '0 : top;
            end else if (up_step) begin
                count_reg <= count_reg + 1'b1;
            end else begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Flags: hardware set wins over software clear
    always_ff @(posedge clk_in) begin
        if (srst) begin
            wrap_reg <= 1'b0;
            trg_reg <= 1'b0;
            trg_ev_reg <= 1'b0;
        end else begin
            wrap_reg <= wrap_now || (wrap_reg && !wrap_flag_clr_in);
            trg_reg <= (do_restart && state_reg == CTC_RUNNING)
                || (trg_reg && !restart_flag_clr_in);
            trg_ev_reg <= do_restart && state_reg == CTC_RUNNING
                && trg_eo_reg;
        end
    end

    // Channel override on fault
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
            assign channel_out[gi] = (fault_reg && nre_reg[gi])
                ? nrv_reg[gi] : channel_wave_in[gi];
        end
    endgenerate

    assign enable_out = enable_reg;
    assign running_out = state_reg == CTC_RUNNING;
    assign dir_out = dir_reg;
    assign count_out = count_reg;
    assign wrap_flag_out = wrap_reg;
    assign restart_flag_out = trg_reg;
    assign restart_event_out = trg_ev_reg;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_prot_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        enable_reg && !srst |=> $stable(act_a_reg))
        else $error("protected field changed while enabled");
    a_wrap_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wrap_now && !srst |=> wrap_reg)
        else $error("wrap flag not set");
    a_wrap_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wrap_now && up_step && !count_we_in && !do_restart && !srst
        |=> count_reg == '0)
        else $error("counter not cleared at top");
    a_write_wins: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        count_we_in && !srst |=> count_reg == $past(count_wdata_in))
        else $error("counter write lost");
    a_cmd_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        running_out && cmd_stop && !srst |=> !running_out)
        else $error("stop command ignored");
    a_single_run: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        running_out && wrap_now && single_reg && !do_restart && !srst
        |=> !running_out)
        else $error("single run did not halt");
    a_soft_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        srst |=> !enable_reg && count_reg == '0)
        else $error("soft reset incomplete");
    a_fault_out: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ev_fault && enable_reg && !srst |=> !running_out && fault_reg)
        else $error("fault action missed");
    c_wrap: cover property (@(posedge clk_in) wrap_now);
    c_restart: cover property (@(posedge clk_in) do_restart && running_out);
    c_fault: cover property (@(posedge clk_in) ev_fault && enable_reg);
endmodule

// ==== verification/ctc_event_model.sv ====
// Event routing model that feeds the two event lines of the core
`timescale 1ns/1ns
module ctc_event_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] fire_in,
    input wire logic level_mode_in,
    input wire logic level_in,
    output logic event_line_a_out,
    output logic event_line_b_out
);
    // One register stage, as the routing fabric adds a cycle
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            event_line_a_out <= 1'b0;
            event_line_b_out <= 1'b0;
        end else begin
            event_line_a_out <= fire_in[0];
            // Line b carries a level when it steers the direction
            event_line_b_out <= level_mode_in ? level_in : fire_in[1];
        end
    end
endmodule

// ==== verification/ctc_core_bench.sv ====
// Self-checking bench for the control timer counter core
`timescale 1ns/1ns
module ctc_core_bench;
    import ctc_pkg::*;
    typedef struct packed {logic [25:0] m; logic [25:0] v;} ctc_note_t;
    // ------------------------------------------------------------
    // Signals and observation word
    // ------------------------------------------------------------
    localparam logic [25:0] M_CNT = 26'h000ffff;
    localparam logic [25:0] M_RF = 26'h0010000;
    localparam logic [25:0] M_WF = 26'h0020000;
    localparam logic [25:0] M_DIR = 26'h0040000;
    localparam logic [25:0] M_RUN = 26'h0080000;
    localparam logic [25:0] M_EN = 26'h0100000;
    localparam logic [25:0] M_CH = 26'h1e00000;
    localparam logic [25:0] M_EV = 26'h2000000;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [8:0] stb = 9'h000;
    logic [6:0] ca = 7'h00;
    logic [15:0] cf = 16'h0000;
    logic [1:0] cmd = 2'h0;
    logic [15:0] cw = 16'h0000;
    logic [15:0] per = 16'h0005;
    logic [15:0] cc0 = 16'h0000;
    logic [3:0] wave = 4'h0;
    logic [1:0] fire = 2'h0;
    logic lmode = 1'b0;
    logic lvl = 1'b0;
    logic ev_a, ev_b, en_o, run_o, dir_o, wf_o, rf_o, rev_o;
    logic [15:0] cnt_o;
    logic [3:0] ch_o;
    logic [25:0] obs;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int sh[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
    int unsigned r;
    ctc_note_t notes[$];
    ctc_note_t nt;
    event look_ev;

    ctc_core i_ctc_core (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .ctla_we_in(stb[0]), .enable_wdata_in(ca[6]),
        .soft_reset_bit_in(ca[5]), .divide_sel_in(ca[4:2]),
        .divide_sync_field_in(ca[1:0]), .cfg_we_in(stb[1]),
        .event_action_a_in(cf[15:13]), .event_action_b_in(cf[12:10]),
        .restart_event_out_bit_in(cf[9]), .top_from_cc0_in(cf[8]),
        .fault_force_enable_bits_in(cf[7:4]),
        .fault_force_value_bits_in(cf[3:0]), .cmd_in(cmd),
        .dir_set_in(stb[3]), .dir_clr_in(stb[4]),
        .single_run_set_in(stb[5]), .single_run_clr_in(stb[6]),
        .count_we_in(stb[2]), .count_wdata_in(cw), .period_in(per),
        .cc0_in(cc0), .channel_wave_in(wave), .event_line_a_in(ev_a),
        .event_line_b_in(ev_b), .wrap_flag_clr_in(stb[7]),
        .restart_flag_clr_in(stb[8]), .enable_out(en_o),
        .running_out(run_o), .dir_out(dir_o), .count_out(cnt_o),
        .wrap_flag_out(wf_o), .restart_flag_out(rf_o),
        .restart_event_out(rev_o), .channel_out(ch_o));

    ctc_event_model i_ctc_event_model (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .fire_in(fire), .level_mode_in(lmode),
        .level_in(lvl), .event_line_a_out(ev_a), .event_line_b_out(ev_b));

    assign obs = {rev_o, ch_o, en_o, run_o, dir_o, wf_o, rf_o, cnt_o};

    // Clock, 50 ns period
    initial begin
        forever #25 clk_in = ~clk_in;
    end

    // Cycle ceiling against a hang
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    // Monitor takes the oldest note and compares
    always @(look_ev) begin
        nt = notes.pop_front();
        check(obs & nt.m, nt.v & nt.m);
    end

    task automatic check(input logic [25:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Note an expected word n edges on, at the falling edge
    task automatic look(input int n, input logic [25:0] m, v);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
        notes.push_back({m, v});
        -> look_ev;
    endtask

    // One-cycle strobe on bit k
    task automatic hit(input int k);
        @(posedge clk_in);
        stb <= 9'h001 << k;
        @(posedge clk_in);
        stb <= 9'h000;
    endtask

    task automatic order(input logic [1:0] c);
        @(posedge clk_in);
        cmd <= c;
        @(posedge clk_in);
        cmd <= CTC_CMD_NONE;
    endtask

    task automatic wcount(input logic [15:0] v);
        cw <= v;
        hit(2);
    endtask

    // Events requested from the routing model, spaced apart
    task automatic ev(input int k, n);
        repeat (n) begin
            @(posedge clk_in);
            fire[k] <= 1'b1;
            @(posedge clk_in);
            fire[k] <= 1'b0;
            @(posedge clk_in);
        end
    endtask

    // Disable, soft reset, configure, then enable
    task automatic setup(input logic [15:0] c, input logic [2:0] dv,
                         input logic [1:0] sy);
        ca <= 7'h00;
        hit(0);
        ca <= 7'h20;
        hit(0);
        cf <= c;
        hit(1);
        ca <= {2'b10, dv, sy};
        hit(0);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        r = $urandom(32'hae19);
        wave = 4'($urandom);
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        look(0, 26'h3ffffff, {5'h0, wave, 17'h0} << 4);
        $display("test end: reset state");
        setup(16'h0000, 3'h0, 2'h0);
        look(0, M_RUN | M_EN, M_RUN | M_EN);
        cf <= {CTC_ACT_COUNT, 13'h0};
        hit(1);
        wcount(16'h0003);
        look(0, M_CNT, 26'h3);
        look(2, M_CNT | M_WF, 26'h5);
        look(1, M_CNT | M_WF, M_WF);
        look(2, M_WF, M_WF);
        hit(7);
        look(0, M_WF, 26'h0);
        $display("test end: free run and wrap");
        per <= 16'hffff;
        foreach (sh[i]) begin
            setup(16'h0000, 3'(i), 2'($urandom_range(1)));
            look(0, M_CNT, 26'h0);
            look(3 << sh[i], M_CNT, 26'h3);
        end
        $display("test end: prescaler ratios");
        per <= 16'h00c8;
        setup(16'h0200, 3'h7, 2'h0);
        wcount(16'h0032);
        order(CTC_CMD_RESTART);
        look(0, M_CNT | M_RF | M_EV | M_RUN, M_RF | M_EV | M_RUN);
        order(CTC_CMD_STOP);
        hit(8);
        wcount(16'h0046);
        look(3, M_CNT | M_RUN | M_RF, 26'h46);
        order(CTC_CMD_RESTART);
        look(0, M_CNT | M_RUN | M_RF, M_RUN | 26'h46);
        hit(3);
        order(CTC_CMD_RESTART);
        look(0, M_CNT | M_RF | M_DIR, M_RF | M_DIR | 26'hc8);
        hit(4);
        order(CTC_CMD_RESTART);
        look(0, M_CNT | M_DIR, 26'h0);
        $display("test end: commands");
        per <= 16'h0009;
        cc0 <= 16'h0004;
        setup(16'h0100, 3'h0, 2'h0);
        hit(3);
        wcount(16'h0001);
        look(1, M_CNT | M_WF, 26'h0);
        look(1, M_CNT | M_WF, M_WF | 26'h4);
        hit(5);
        wcount(16'h0002);
        look(8, M_RUN, 26'h0);
        hit(6);
        order(CTC_CMD_RESTART);
        look(5, M_RUN | M_CNT, M_RUN | 26'h4);
        $display("test end: down count and single run");
        setup({CTC_ACT_COUNT, CTC_ACT_DIR, 10'h0}, 3'h0, 2'h0);
        wcount(16'h000a);
        lmode <= 1'b1;
        lvl <= 1'b1;
        ev(0, 3);
        look(2, M_CNT | M_DIR, M_DIR | 26'h7);
        lvl <= 1'b0;
        ev(0, 1);
        look(2, M_CNT | M_DIR, 26'h8);
        lmode <= 1'b0;
        setup({CTC_ACT_STEP, CTC_ACT_STEP, 10'h0}, 3'h0, 2'h0);
        hit(3);
        wcount(16'h000a);
        ev(0, 3);
        ev(1, 1);
        look(2, M_CNT, 26'hc);
        $display("test end: counting events");
        setup({CTC_ACT_START, CTC_ACT_STOP, 10'h0}, 3'h7, 2'h0);
        look(3, M_RUN, 26'h0);
        ev(0, 1);
        look(1, M_RUN, M_RUN);
        ev(1, 1);
        look(1, M_RUN, 26'h0);
        setup({CTC_ACT_RESTART, 13'h0}, 3'h7, 2'h0);
        wcount(16'h000a);
        look(1, M_RUN | M_CNT, 26'ha);
        ev(0, 1);
        look(1, M_RUN | M_RF, M_RUN);
        ev(0, 1);
        look(1, M_RF | M_CNT, M_RF);
        setup({CTC_ACT_FAULT, 5'h0, 8'h53}, 3'h0, 2'h0);
        ev(0, 1);
        look(1, M_RUN | M_CH, {1'b0, 4'h1 | (4'ha & wave), 21'h0});
        $display("test end: start, stop, restart and fault events");
        repeat (4) @(posedge clk_in);
        give_verdict();
    end
endmodule
